// file: shared/art_map.svh
`ifndef ART_MAP_SVH
`define ART_MAP_SVH

// Counter geometry
`define ART_CW        12
`define ART_CNT_MAX   12'hFFF
`define ART_CNT_RST   12'h000
`define ART_SLOW_MAX  5'h1F

// Register indices; byte address is four times the index
`define ART_IDX_CSR   6'h0D
`define ART_IDX_CNTH  6'h0E
`define ART_IDX_CNTL  6'h0F
`define ART_IDX_RLDH  6'h10
`define ART_IDX_RLDL  6'h11
`define ART_IDX_OE    6'h12
`define ART_IDX_CH0   6'h13
`define ART_IDX_CH3   6'h16
`define ART_IDX_DCR0H 6'h17
`define ART_IDX_DCR3L 6'h1E
`define ART_IDX_CAPH  6'h1F
`define ART_IDX_CAPL  6'h20
`define ART_IDX_TRAN  6'h21
`define ART_IDX_BRK   6'h22

// Control-status fields
`define ART_CSR_ICF   6
`define ART_CSR_CAPTURE_IRQ_ENABLE  5
`define ART_CSR_CKH   4
`define ART_CSR_CKL   3
`define ART_CSR_OVF   2
`define ART_CSR_OVERFLOW_IRQ_ENABLE 1
`define ART_CSR_COMPARE_IRQ_ENABLE 0

// Channel status-control fields
`define ART_CH_INV    1
`define ART_CH_COMPARE_MATCH_FLAG   0

// Break control fields
`define ART_BRK_BA    5
`define ART_BRK_BREAK_PIN_ENABLE  4
`define ART_BRK_PATH  3

// Transfer control
`define ART_TRAN_BIT  0
`define ART_TRAN_RST  1'b1

// Counter clock select codes
`define ART_CK_OFF    2'b00
`define ART_CK_LITE   2'b01
`define ART_CK_CPU    2'b10
`define ART_CK_FAST   2'b11

`endif

// file: shared/art_pkg.sv
package art_pkg;

  typedef struct packed {
    logic [11:0] duty_act;
    logic        inv_sh;
    logic        level;
  } art_chan_t;

  typedef struct packed {
    logic [11:0]      cnt;
    logic [11:0]      reload;
    logic [3:0][11:0] duty;
    logic [3:0]       oe;
    logic [3:0]       inv;
    logic [3:0]       compare_match_flag;
    logic             capture_flag;
    logic             capture_irq_enable;
    logic [1:0]       ck;
    logic             ovf;
    logic             overflow_irq_enable;
    logic             compare_irq_enable;
    logic             ba;
    logic             break_pin_enable;
    logic [3:0]       pat;
    logic             xfer;
    logic [11:0]      cap;
    logic             cap_prev;
    logic [4:0]       pre;
    logic             rdy;
    logic [31:0]      prdata;
    logic             slverr;
    logic [3:0]       pwm;
    logic [3:0]       alt;
    logic             irq_ovf;
    logic             irq_cc;
  } art_top_t;

endpackage : art_pkg

// file: core/art_sync.sv
module art_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } art_sync_t;

  art_sync_t s;
  art_sync_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;

endmodule : art_sync

// file: core/art_chan.sv
`include "art_map.svh"

module art_chan
  import art_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Settings
  input  wire logic [11:0] duty_pre,
  input  wire logic        inv,
  input  wire logic        xfer_en,
  input  wire logic        clear,
  // Counter events
  input  wire logic        step,
  input  wire logic        ovf,
  input  wire logic [11:0] cnt_nx,
  // Results
  output logic             match,
  output logic             wave
);

  art_chan_t s;
  art_chan_t next_s;

  // Overflow owns the cycle; duty above reload keeps them apart
  assign match = step && !ovf && (cnt_nx == s.duty_act)
                 && (s.duty_act != `ART_CNT_RST);
  assign wave  = s.level ^ s.inv_sh;

  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.duty_act = `ART_CNT_RST;
      next_s.level    = 1'b0;
    end else if (ovf) begin
      next_s.level = 1'b1;
      if (xfer_en) begin
        next_s.duty_act = duty_pre;
      end
    end else if (match) begin
      next_s.level = 1'b0;
    end
    // Without transfer mode the invert acts at once
    if (!xfer_en || ovf) begin
      next_s.inv_sh = inv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : art_chan

// file: core/art_timer.sv
`include "art_map.svh"

module art_timer
  import art_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Counter clock ticks, same clock domain
  input  wire logic        lite_tick,
  input  wire logic        fast_tick,
  // Power modes
  input  wire logic        slow_mode,
  input  wire logic        halt_mode,
  input  wire logic        active_halt,
  // Pins
  input  wire logic        break_n_pin,
  input  wire logic        capture_input,
  output logic      [3:0]  pwm_channel_out,
  output logic      [3:0]  pwm_alt_en,
  // Interrupt requests
  output logic             ovf_irq,
  output logic             cmp_cap_irq
);

  art_top_t s;
  art_top_t next_s;

  logic [1:0]  pin_s;
  logic        brk_n_s;
  logic        cap_s;
  logic        src;
  logic        run;
  logic        step;
  logic        wrap;
  logic        pwm_ok;
  logic [11:0] cnt_nx;
  logic [3:0]  match;
  logic [3:0]  wave;
  logic [5:0]  idx;
  logic [5:0]  doff;
  logic [5:0]  coff;
  logic        is_dcr;
  logic        is_ch;
  logic        hit;
  logic [31:0] rd_data;
  logic        acc;

  // Both pins come from outside the clock domain
  art_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({break_n_pin, capture_input}),
    .q     (pin_s)
  );

  // Sync resets to zero; a low break pin is only seen once synced
  assign brk_n_s = pin_s[1] | ~s.break_pin_enable;
  assign cap_s   = pin_s[0];

  // Counter clock source and power gating
  always_comb begin
    case (s.ck)
      `ART_CK_LITE: src = lite_tick;
      `ART_CK_CPU:  src = 1'b1;
      `ART_CK_FAST: src = fast_tick;
      default:      src = 1'b0;
    endcase
  end

  assign run = !halt_mode && !s.ba
               && !(active_halt && !(s.ck == `ART_CK_LITE && s.overflow_irq_enable));
  assign step   = src && run
                  && (!slow_mode || s.pre == `ART_SLOW_MAX);
  assign wrap   = step && (s.cnt == `ART_CNT_MAX);
  assign cnt_nx = wrap ? s.reload : s.cnt + 12'h001;
  assign pwm_ok = s.ck != `ART_CK_LITE;

  for (genvar i = 0; i < 4; i++) begin : g_chan
    art_chan u_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .duty_pre (s.duty[i]),
      .inv      (s.inv[i]),
      .xfer_en  (s.xfer),
      .clear    (s.ba),
      .step     (step && pwm_ok),
      .ovf      (wrap && pwm_ok),
      .cnt_nx   (cnt_nx),
      .match    (match[i]),
      .wave     (wave[i])
    );
  end

  // Address decode
  assign idx    = paddr[7:2];
  assign doff   = idx - `ART_IDX_DCR0H;
  assign coff   = idx - `ART_IDX_CH0;
  assign is_dcr = idx >= `ART_IDX_DCR0H && idx <= `ART_IDX_DCR3L;
  assign is_ch  = idx >= `ART_IDX_CH0 && idx <= `ART_IDX_CH3;

  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = paddr[1:0] == 2'b00;
    if (is_dcr) begin
      if (doff[0]) begin
        rd_data[7:0] = s.duty[doff[2:1]][7:0];
      end else begin
        rd_data[3:0] = s.duty[doff[2:1]][11:8];
      end
    end else if (is_ch) begin
      rd_data[`ART_CH_INV]  = s.inv[coff[1:0]];
      rd_data[`ART_CH_COMPARE_MATCH_FLAG] = s.compare_match_flag[coff[1:0]];
    end else begin
      case (idx)
        `ART_IDX_CSR: begin
          rd_data[`ART_CSR_ICF]   = s.capture_flag;
          rd_data[`ART_CSR_CAPTURE_IRQ_ENABLE]  = s.capture_irq_enable;
          rd_data[`ART_CSR_CKH]   = s.ck[1];
          rd_data[`ART_CSR_CKL]   = s.ck[0];
          rd_data[`ART_CSR_OVF]   = s.ovf;
          rd_data[`ART_CSR_OVERFLOW_IRQ_ENABLE] = s.overflow_irq_enable;
          rd_data[`ART_CSR_COMPARE_IRQ_ENABLE] = s.compare_irq_enable;
        end
        `ART_IDX_CNTH: rd_data[3:0] = s.cnt[11:8];
        `ART_IDX_CNTL: rd_data[7:0] = s.cnt[7:0];
        `ART_IDX_RLDH: rd_data[3:0] = s.reload[11:8];
        `ART_IDX_RLDL: rd_data[7:0] = s.reload[7:0];
        `ART_IDX_OE: begin
          rd_data[6] = s.oe[3];
          rd_data[4] = s.oe[2];
          rd_data[2] = s.oe[1];
          rd_data[0] = s.oe[0];
        end
        `ART_IDX_CAPH: rd_data[3:0] = s.cap[11:8];
        `ART_IDX_CAPL: rd_data[7:0] = s.cap[7:0];
        `ART_IDX_TRAN: rd_data[`ART_TRAN_BIT] = s.xfer;
        `ART_IDX_BRK: begin
          rd_data[`ART_BRK_BA]   = s.ba;
          rd_data[`ART_BRK_BREAK_PIN_ENABLE] = s.break_pin_enable;
          rd_data[3:0]           = s.pat;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // Second access cycle completes the transfer
  assign acc = psel && penable && s.rdy;

  always_comb begin
    next_s     = s;
    next_s.rdy = psel && penable && !s.rdy;
    if (psel && penable && !s.rdy) begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rd_data;
      next_s.slverr = !hit;
    end

    // Software writes
    if (acc && pwrite && hit) begin
      if (is_dcr) begin
        if (doff[0]) begin
          next_s.duty[doff[2:1]][7:0] = pwdata[7:0];
        end else begin
          next_s.duty[doff[2:1]][11:8] = pwdata[3:0];
        end
      end else if (is_ch) begin
        next_s.inv[coff[1:0]] = pwdata[`ART_CH_INV];
      end else begin
        case (idx)
          `ART_IDX_CSR: begin
            // Flag bits ignore writes
            next_s.capture_irq_enable  = pwdata[`ART_CSR_CAPTURE_IRQ_ENABLE];
            next_s.ck    = pwdata[`ART_CSR_CKH:`ART_CSR_CKL];
            next_s.overflow_irq_enable = pwdata[`ART_CSR_OVERFLOW_IRQ_ENABLE];
            next_s.compare_irq_enable = pwdata[`ART_CSR_COMPARE_IRQ_ENABLE];
          end
          `ART_IDX_RLDH: next_s.reload[11:8] = pwdata[3:0];
          `ART_IDX_RLDL: next_s.reload[7:0]  = pwdata[7:0];
          `ART_IDX_OE: begin
            next_s.oe = {pwdata[6], pwdata[4], pwdata[2], pwdata[0]};
          end
          `ART_IDX_TRAN: next_s.xfer = pwdata[`ART_TRAN_BIT];
          `ART_IDX_BRK: begin
            next_s.ba   = pwdata[`ART_BRK_BA];
            next_s.break_pin_enable = pwdata[`ART_BRK_BREAK_PIN_ENABLE];
            next_s.pat  = pwdata[`ART_BRK_PATH:0];
          end
          default: ;
        endcase
      end
    end

    // Read side effects
    if (acc && !pwrite && hit) begin
      if (is_ch) begin
        next_s.compare_match_flag[coff[1:0]] = 1'b0;
      end else if (idx == `ART_IDX_CSR) begin
        next_s.ovf = 1'b0;
      end else if (idx == `ART_IDX_CAPH || idx == `ART_IDX_CAPL) begin
        next_s.capture_flag = 1'b0;
      end
    end

    // Prescaler for slow mode
    if (src && run && slow_mode) begin
      next_s.pre = s.pre + 5'h01;
    end else if (!slow_mode) begin
      next_s.pre = 5'h00;
    end

    // Counter; hardware events follow so a set beats a clear
    if (step) begin
      next_s.cnt = cnt_nx;
    end
    if (wrap) begin
      next_s.ovf = 1'b1;
      if (pwm_ok && s.xfer) begin
        next_s.xfer = 1'b0;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (match[i]) begin
        next_s.compare_match_flag[i] = 1'b1;
      end
    end

    // Capture stays frozen while its flag is up
    next_s.cap_prev = cap_s;
    if ((cap_s ^ s.cap_prev) && !s.capture_flag) begin
      next_s.cap = s.cnt;
      next_s.capture_flag = 1'b1;
    end

    if (!brk_n_s) begin
      next_s.ba = 1'b1;
    end
    if (next_s.ba) begin
      next_s.cnt    = `ART_CNT_RST;
      next_s.reload = `ART_CNT_RST;
      next_s.duty   = '0;
      next_s.oe     = 4'h0;
    end

    // Registered pin and request outputs
    next_s.pwm = next_s.ba ? next_s.pat : wave;
    next_s.alt = next_s.ba ? 4'hF : next_s.oe;
    next_s.irq_ovf = next_s.ovf && next_s.overflow_irq_enable;
    next_s.irq_cc  = (|(next_s.compare_match_flag) && next_s.compare_irq_enable)
                     || (next_s.capture_flag && next_s.capture_irq_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.xfer <= `ART_TRAN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata          = s.prdata;
  assign pready          = s.rdy;
  assign pslverr         = s.slverr;
  assign pwm_channel_out = s.pwm;
  assign pwm_alt_en      = s.alt;
  assign ovf_irq         = s.irq_ovf;
  assign cmp_cap_irq     = s.irq_cc;

endmodule : art_timer

// file: testbench/art_timer_assertions.sv
module art_timer_assertions (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and requests
  input wire logic        break_n_pin,
  input wire logic [3:0]  pwm_channel_out,
  input wire logic [3:0]  pwm_alt_en,
  input wire logic        ovf_irq,
  input wire logic        cmp_cap_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pat_w;
  logic       acc_w;
  logic       csr_w;
  assign pat_w = pwdata[3:0];
  assign acc_w = pready && pwrite;
  assign csr_w = pready && paddr == 8'h34;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_after_wait_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("access not completed after one wait state");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  unmapped_err_a: assert property (
    pready && paddr == 8'hFC |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  ovf_clear_a: assert property (
    $fell(ovf_irq) |-> $past(csr_w))
    else $error("overflow request fell without control access");
  irq_clear_a: assert property (
    $fell(cmp_cap_irq) |-> $past(pready))
    else $error("compare or capture request fell without access");
  brk_pattern_a: assert property (
    pready && pwrite && paddr == 8'h88 && pwdata[5] |=>
      pwm_alt_en == 4'hF && pwm_channel_out == $past(pat_w))
    else $error("break pattern not driven after break write");
  // Pin-driven break is excluded for the synchroniser depth
  alt_src_a: assert property (
    $changed(pwm_alt_en) && $past(break_n_pin) && $past(break_n_pin, 2)
      && $past(break_n_pin, 3) && $past(break_n_pin, 4) |-> $past(acc_w))
    else $error("pin ownership changed without a write");

  cover property (pready && pwrite && paddr == 8'h88);
  cover property ($rose(ovf_irq));
  cover property ($rose(cmp_cap_irq));
endmodule : art_timer_assertions

bind art_timer art_timer_assertions art_timer_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .break_n_pin(break_n_pin),
  .pwm_channel_out(pwm_channel_out), .pwm_alt_en(pwm_alt_en),
  .ovf_irq(ovf_irq), .cmp_cap_irq(cmp_cap_irq));

// file: testbench/art_timer_tb.sv
`include "art_map.svh"
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module art_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] RLD = 12'hFF0;
  localparam logic [11:0] DTY = 12'hFFC;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0]  paddr, k1;
  logic [31:0] pwdata, prdata, rv;
  logic        lite_tick, fast_tick, slow_mode, halt_mode, active_halt;
  logic        break_n_pin, capture_input, ovf_irq, cmp_cap_irq;
  logic [3:0]  pwm_channel_out, pwm_alt_en;
  int          fails = 0;
  int          checks = 0;
  int          h, l, x;

  art_timer art_timer_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .lite_tick, .fast_tick,
    .slow_mode, .halt_mode, .active_halt, .break_n_pin, .capture_input,
    .pwm_channel_out, .pwm_alt_en, .ovf_irq, .cmp_cap_irq);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [5:0] i,
                     input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      tally_and_finish();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input string s, input logic [5:0] i,
                    input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CK(s, e, rv[7:0] & m)
  endtask : rc

  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask : wt

  function automatic logic sg(input int k);
    return k == 0 ? pwm_channel_out[0] : k == 1 ? ovf_irq : cmp_cap_irq;
  endfunction : sg

  task automatic wl(input int k, input logic v, output int c);
    c = 0;
    while (sg(k) !== v && c < 5000) begin
      @(negedge pclk);
      c++;
    end
    if (c >= 5000) begin
      fails++;
      tally_and_finish();
    end
  endtask : wl

  task automatic t_reset;
    rc("csr", `ART_IDX_CSR, 8'hFF, 8'h00);
    rc("cntl", `ART_IDX_CNTL, 8'hFF, 8'h00);
    rc("tran", `ART_IDX_TRAN, 8'hFF, 8'h01);
    rc("oe", `ART_IDX_OE, 8'hFF, 8'h00);
    apb(1'b0, 6'h3F, 8'h00);
    `CK("unmapped err", 1'b1, re)
  endtask : t_reset

  task automatic t_pwm;
    apb(1'b1, `ART_IDX_RLDH, {4'h0, RLD[11:8]});
    apb(1'b1, `ART_IDX_RLDL, RLD[7:0]);
    apb(1'b1, `ART_IDX_DCR0H, {4'h0, DTY[11:8]});
    apb(1'b1, `ART_IDX_DCR0H + 6'h1, DTY[7:0]);
    apb(1'b1, `ART_IDX_OE, 8'h01);
    apb(1'b1, `ART_IDX_CSR, 8'h13);
    wl(1, 1'b1, x);
    wl(0, 1'b0, x);
    wl(0, 1'b1, x);
    wl(0, 1'b0, h);
    wl(0, 1'b1, l);
    `CK("high", DTY - RLD, h)
    `CK("period", 13'h1000 - RLD, h + l)
    `CK("alt", 4'h1, pwm_alt_en)
    `CK("cmp irq", 1'b1, cmp_cap_irq)
    rc("tran", `ART_IDX_TRAN, 8'hFF, 8'h00);
    apb(1'b1, `ART_IDX_CH0, 8'h02);
    wl(0, 1'b0, x);
    wl(0, 1'b1, x);
    wl(0, 1'b0, h);
    `CK("inv high", 13'h1000 - DTY, h)
    apb(1'b1, `ART_IDX_CSR, 8'h00);
    rc("ovf", `ART_IDX_CSR, 8'h04, 8'h04);
    rc("ovf clr", `ART_IDX_CSR, 8'h04, 8'h00);
    rc("compare_match_flag", `ART_IDX_CH0, 8'h01, 8'h01);
    rc("compare_match_flag clr", `ART_IDX_CH0, 8'h01, 8'h00);
    rc("compare_match_flag zero", `ART_IDX_CH0 + 6'h1, 8'h01, 8'h00);
    rc("cnth", `ART_IDX_CNTH, 8'hFF, {4'h0, RLD[11:8]});
    apb(1'b0, `ART_IDX_CNTL, 8'h00);
    k1 = rv[7:0];
    rc("hold", `ART_IDX_CNTL, 8'hFF, k1);
  endtask : t_pwm

  // Lite tick runs the counter but must raise no compare event
  task automatic t_lite;
    apb(1'b1, `ART_IDX_CSR, 8'h08);
    lite_tick <= 1'b1;
    wt(40);
    @(posedge pclk);
    lite_tick <= 1'b0;
    rc("lite ovf", `ART_IDX_CSR, 8'h04, 8'h04);
    rc("lite compare_match_flag", `ART_IDX_CH0, 8'h01, 8'h00);
    apb(1'b1, `ART_IDX_CSR, 8'h00);
  endtask : t_lite

  task automatic t_break;
    apb(1'b1, `ART_IDX_BRK, 8'h25);
    wt(1);
    `CK("pattern", 4'h5, pwm_channel_out)
    `CK("alt", 4'hF, pwm_alt_en)
    rc("oe", `ART_IDX_OE, 8'hFF, 8'h00);
    rc("rldl", `ART_IDX_RLDL, 8'hFF, 8'h00);
    rc("dcr", `ART_IDX_DCR0H + 6'h1, 8'hFF, 8'h00);
    rc("cntl", `ART_IDX_CNTL, 8'hFF, 8'h00);
    apb(1'b1, `ART_IDX_BRK, 8'h00);
    wt(1);
    `CK("alt", 4'h0, pwm_alt_en)
    apb(1'b1, `ART_IDX_BRK, 8'h10);
    break_n_pin <= 1'b0;
    wt(6);
    `CK("pin alt", 4'hF, pwm_alt_en)
    @(posedge pclk);
    break_n_pin <= 1'b1;
    rc("ba", `ART_IDX_BRK, 8'h20, 8'h20);
    apb(1'b1, `ART_IDX_BRK, 8'h00);
  endtask : t_break

  task automatic t_capture;
    apb(1'b1, `ART_IDX_CSR, 8'h10);
    apb(1'b1, `ART_IDX_CSR, 8'h00);
    apb(1'b0, `ART_IDX_CNTL, 8'h00);
    k1 = rv[7:0];
    capture_input <= ~capture_input;
    wt(6);
    rc("icf", `ART_IDX_CSR, 8'h40, 8'h40);
    apb(1'b1, `ART_IDX_CSR, 8'h10);
    apb(1'b1, `ART_IDX_CSR, 8'h00);
    capture_input <= ~capture_input;
    wt(6);
    rc("cap", `ART_IDX_CAPL, 8'hFF, k1);
    rc("icf clr", `ART_IDX_CSR, 8'h40, 8'h00);
    apb(1'b1, `ART_IDX_CSR, 8'h40);
    rc("icf ro", `ART_IDX_CSR, 8'h40, 8'h00);
    halt_mode <= 1'b1;
    apb(1'b1, `ART_IDX_CSR, 8'h10);
    apb(1'b0, `ART_IDX_CNTL, 8'h00);
    k1 = rv[7:0];
    rc("halt", `ART_IDX_CNTL, 8'hFF, k1);
    halt_mode <= 1'b0;
    slow_mode <= 1'b1;
    apb(1'b0, `ART_IDX_CNTL, 8'h00);
    k1 = rv[7:0];
    wt(20);
    apb(1'b0, `ART_IDX_CNTL, 8'h00);
    `CK("slow", 1'b1, rv[7:0] - k1 <= 8'h01)
    slow_mode <= 1'b0;
  endtask : t_capture

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lite_tick = 1'b0;
    fast_tick = 1'b0;
    slow_mode = 1'b0;
    halt_mode = 1'b0;
    active_halt = 1'b0;
    break_n_pin = 1'b1;
    capture_input = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pwm();
    t_lite();
    t_break();
    t_capture();
    tally_and_finish();
  end
endmodule : art_timer_tb
